// ### hdl/sync_router_pkg.sv
// Package with the timing signal indices, roles and trigger source codes.
package sync_router_pkg;
  localparam int unsigned NUM_SIGNALS = 6;
  localparam int unsigned ROLE_W      = 2;
  localparam int unsigned IDX_TIMEBASE   = 0;
  localparam int unsigned IDX_IN_TRIG    = 1;
  localparam int unsigned IDX_CONVERSION = 2;
  localparam int unsigned IDX_SCAN_START = 3;
  localparam int unsigned IDX_OUT_TRIG   = 4;
  localparam int unsigned IDX_OUT_UPDATE = 5;

  typedef enum logic [1:0] {
    ROLE_DISABLED = 2'h0,
    ROLE_MASTER   = 2'h1,
    ROLE_SLAVE    = 2'h2
  } role_t;

  typedef enum logic [1:0] {
    TRIG_SOFTWARE = 2'h0,
    TRIG_ANALOG   = 2'h1,
    TRIG_DIGITAL  = 2'h2,
    TRIG_SYNC_BUS = 2'h3
  } trig_src_t;

  localparam logic [1:0] ROLE_RESET = 2'h0;
  localparam logic [1:0] SRC_RESET  = 2'h0;
endpackage

// ### hdl/sync_lane_if.sv
// Interface carrying the per-signal routing between the router and its lane logic.
`timescale 1ns/10ps
interface sync_lane_if #(parameter int unsigned N = 6);
  logic [N-1:0] is_master;
  logic [N-1:0] is_slave;
  logic [N-1:0] internal_sig;
  logic [N-1:0] line_in;
  logic [N-1:0] routed_d;
  logic [N-1:0] drive_d;
  modport router (output is_master, output is_slave, output internal_sig, output line_in,
                  input routed_d, input drive_d);
  modport lanes  (input is_master, input is_slave, input internal_sig, input line_in,
                  output routed_d, output drive_d);
endinterface

// ### hdl/sync_lanes.sv
// Per-signal master, slave or disabled selection for the sync bus lines.
`timescale 1ns/10ps
module sync_lanes #(
  parameter int unsigned N = 6
) (
  sync_lane_if.lanes lanes
);
  // A lane count of zero leaves nothing to route.
  if (N == 0) begin : g_bad_n
    $error("sync_lanes needs at least one lane");
  end

  // Slaves substitute the line, others keep their own signal.
  assign lanes.routed_d = (lanes.is_slave & lanes.line_in)
                        | (~lanes.is_slave & lanes.internal_sig);
  // Only a master enables its line driver.
  assign lanes.drive_d  = lanes.is_master;
endmodule

// ### hdl/card_timing_sync_router.sv
// Top of the card timing router between internal timing and the sync bus.
// What this block does
// - Conversion master drives its internal conversion signal onto line.
// - Each of six signals has its own role.
// - Master drives internal signal onto sync line.
// - Reset returns all signals to internal source.
// - Input echo follows selected input trigger source.
// - Output echo follows selected output trigger source.
// - Slave uses incoming line instead of internal.
`timescale 1ns/10ps
module card_timing_sync_router #(
  parameter int unsigned N = sync_router_pkg::NUM_SIGNALS
) (
  // Clock and reset.
  input  wire logic         clock,
  input  wire logic         sys_rst,
  // Role per timing signal, two bits each.
  input  wire logic [2*N-1:0] role_cfg,
  // Trigger source selection.
  input  wire logic [1:0]   in_trig_sel,
  input  wire logic [1:0]   out_trig_sel,
  // Trigger sources for the input side.
  input  wire logic         in_trig_sw,
  input  wire logic         in_trig_analog,
  input  wire logic         in_trig_digital,
  // Trigger sources for the output side.
  input  wire logic         out_trig_sw,
  input  wire logic         out_trig_analog,
  input  wire logic         out_trig_digital,
  // Internally generated timing signals.
  input  wire logic [N-1:0] internal_timing,
  // Sync bus lines, one per signal.
  input  wire logic [N-1:0] board_sync_bus_in,
  output logic      [N-1:0] board_sync_bus_out,
  output logic      [N-1:0] board_sync_bus_oe,
  // Timing signals as used by the card.
  output logic      [N-1:0] timing_used,
  // Trigger echoes.
  output logic              input_trigger_echo,
  output logic              output_trigger_echo
);
  ////////////////////////////////////////////////////////////////////////////
  // Parameter check.

  // The lane indices are fixed, so only six lanes can be served.
  if (N != sync_router_pkg::NUM_SIGNALS) begin : g_bad_n
    $error("card_timing_sync_router supports exactly six timing signals");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers, cleared to internal sourcing on reset.

  logic [sync_router_pkg::ROLE_W*N-1:0] role_q;
  logic [1:0]                           in_sel_q;
  logic [1:0]                           out_sel_q;
  logic [N-1:0]                         bus_meta_q;
  logic [N-1:0]                         bus_sync_q;

  // Roles are registered first, so a new setting reaches every lane in one cycle.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      role_q <= {N{sync_router_pkg::ROLE_RESET}};
    end else begin
      role_q <= role_cfg;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      in_sel_q <= sync_router_pkg::SRC_RESET;
    end else begin
      in_sel_q <= in_trig_sel;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      out_sel_q <= sync_router_pkg::SRC_RESET;
    end else begin
      out_sel_q <= out_trig_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synchroniser for the lines driven by the other boards.

  // Only the second stage is read by logic, since the first may still be settling.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bus_meta_q <= '0;
    end else begin
      bus_meta_q <= board_sync_bus_in;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bus_sync_q <= '0;
    end else begin
      bus_sync_q <= bus_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Role decoding and lane selection.

  function automatic logic role_is(
    input logic [1:0] r,
    input logic [1:0] want
  );
    role_is = (r == want);
  endfunction

  sync_lane_if #(.N(N)) lane_bus ();

  wire logic [N-1:0] master_w;
  wire logic [N-1:0] slave_w;

  // Code three is reserved and decodes as neither role, so it acts as disabled.
  for (genvar i = 0; i < N; i++) begin : g_role
    wire logic [1:0] code_w;
    assign code_w      = role_q[sync_router_pkg::ROLE_W*i +: sync_router_pkg::ROLE_W];
    assign master_w[i] = role_is(code_w, sync_router_pkg::ROLE_MASTER);
    assign slave_w[i]  = role_is(code_w, sync_router_pkg::ROLE_SLAVE);
  end

  assign lane_bus.is_master    = master_w;
  assign lane_bus.is_slave     = slave_w;
  assign lane_bus.internal_sig = internal_timing;
  assign lane_bus.line_in      = bus_sync_q;

  sync_lanes #(.N(N)) u_lanes (
    .lanes (lane_bus.lanes)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Trigger echo selection.

  function automatic logic pick_trig(
    input logic [1:0] sel,
    input logic       sw,
    input logic       an,
    input logic       dg,
    input logic       sb
  );
    unique case (sel)
      sync_router_pkg::TRIG_SOFTWARE: pick_trig = sw;
      sync_router_pkg::TRIG_ANALOG:   pick_trig = an;
      sync_router_pkg::TRIG_DIGITAL:  pick_trig = dg;
      sync_router_pkg::TRIG_SYNC_BUS: pick_trig = sb;
    endcase
  endfunction

  wire logic in_echo_w;
  wire logic out_echo_w;

  // A sync-bus trigger passes the line synchroniser, so it echoes three cycles later.
  assign in_echo_w  = pick_trig(in_sel_q, in_trig_sw, in_trig_analog, in_trig_digital,
                                bus_sync_q[sync_router_pkg::IDX_IN_TRIG]);
  assign out_echo_w = pick_trig(out_sel_q, out_trig_sw, out_trig_analog, out_trig_digital,
                                bus_sync_q[sync_router_pkg::IDX_OUT_TRIG]);

  ////////////////////////////////////////////////////////////////////////////
  // Next values of the output registers.

  wire logic [N-1:0] bus_out_d;
  wire logic [N-1:0] bus_oe_d;
  wire logic [N-1:0] used_d;

  // Data is gated by the enable, so a released line never carries local timing.
  assign bus_out_d = internal_timing & lane_bus.drive_d;
  assign bus_oe_d  = lane_bus.drive_d;
  assign used_d    = lane_bus.routed_d;

  ////////////////////////////////////////////////////////////////////////////
  // Output registers.

  // Data and enable move on the same edge, so a driver never shows stale data.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      board_sync_bus_out <= '0;
    end else begin
      board_sync_bus_out <= bus_out_d;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      board_sync_bus_oe <= '0;
    end else begin
      board_sync_bus_oe <= bus_oe_d;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      timing_used <= '0;
    end else begin
      timing_used <= used_d;
    end
  end

  // The echoes are registered so that they leave the board free of select glitches.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      input_trigger_echo <= '0;
    end else begin
      input_trigger_echo <= in_echo_w;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      output_trigger_echo <= '0;
    end else begin
      output_trigger_echo <= out_echo_w;
    end
  end
endmodule

// ### verif/peer_board.sv
// Peer board on the shared sync lines, driving only where this board does not.
`timescale 1ns/10ps
module peer_board (
  input  wire logic       clock,
  input  wire logic [5:0] peer_en,
  input  wire logic [5:0] peer_val,
  input  wire logic [5:0] dut_oe,
  input  wire logic [5:0] dut_out,
  output logic      [5:0] line
);
  logic [5:0] last_q = 6'h00;
  always_ff @(posedge clock) last_q <= ~last_q;
  // A line that nobody drives toggles, so it is never read as held data.
  assign line = (dut_oe & dut_out) | (~dut_oe & peer_en & peer_val)
              | (~dut_oe & ~peer_en & ~last_q);
endmodule

// ### verif/card_timing_sync_router_monitor.sv
// Concurrent checks on the router ports.
`timescale 1ns/10ps
module card_timing_sync_router_monitor #(parameter int unsigned N = 6) (
  input wire logic clock, sys_rst,
  input wire logic [2*N-1:0] role_cfg,
  input wire logic [1:0] in_trig_sel, out_trig_sel,
  input wire logic in_trig_sw, in_trig_analog, in_trig_digital,
  input wire logic out_trig_sw, out_trig_analog, out_trig_digital,
  input wire logic [N-1:0] internal_timing, board_sync_bus_in, board_sync_bus_out,
  input wire logic [N-1:0] board_sync_bus_oe, timing_used,
  input wire logic input_trigger_echo, output_trigger_echo
);
  logic [1:0] up_q;
  wire logic ok = up_q == 2'h3;
  wire logic [2:0] iv = {in_trig_digital, in_trig_analog, in_trig_sw};
  wire logic [2:0] ov = {out_trig_digital, out_trig_analog, out_trig_sw};
  // The past values reach three edges back, so checks wait that long after reset.
  always_ff @(posedge clock) begin
    if (sys_rst) up_q <= 2'h0;
    else if (!ok) up_q <= up_q + 2'h1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  for (genvar i = 0; i < N; i++) begin : g_sig
    chk_master_drive: assert property (
      ok && $past(role_cfg[2*i+:2], 2) == 2'h1 |-> board_sync_bus_oe[i]
      && board_sync_bus_out[i] == $past(internal_timing[i])) else $error("master line");
    chk_idle_release: assert property (
      ok && $past(role_cfg[2*i+:2], 2) != 2'h1 |-> !board_sync_bus_oe[i]
      && !board_sync_bus_out[i]) else $error("idle line driven");
    chk_slave_line: assert property (
      ok && $past(role_cfg[2*i+:2], 2) == 2'h2 |->
      timing_used[i] == $past(board_sync_bus_in[i], 3)) else $error("slave source");
    chk_local_source: assert property (
      ok && $past(role_cfg[2*i+:2], 2) != 2'h2 |->
      timing_used[i] == $past(internal_timing[i])) else $error("local source");
  end
  chk_reset_clear: assert property ($past(sys_rst) |->
    board_sync_bus_oe == '0 && board_sync_bus_out == '0 && timing_used == '0)
    else $error("reset outputs");
  chk_reset_echo: assert property ($past(sys_rst) |->
    !input_trigger_echo && !output_trigger_echo) else $error("reset echoes");
  chk_in_echo: assert property (
    ok && $past(in_trig_sel) == $past(in_trig_sel, 2) |-> input_trigger_echo ==
    ($past(in_trig_sel) == 2'h3 ? $past(board_sync_bus_in[1], 3) : $past(iv[in_trig_sel])))
    else $error("input echo");
  chk_out_echo: assert property (
    ok && $past(out_trig_sel) == $past(out_trig_sel, 2) |-> output_trigger_echo ==
    ($past(out_trig_sel) == 2'h3 ? $past(board_sync_bus_in[4], 3) : $past(ov[out_trig_sel])))
    else $error("output echo");
endmodule
bind card_timing_sync_router card_timing_sync_router_monitor #(.N(N)) mon (.*);

// ### verif/card_timing_sync_router_test.sv
// Self-checking bench for the card timing router.
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module card_timing_sync_router_test;
  logic clock = 1'b0, sys_rst = 1'b1, input_trigger_echo, output_trigger_echo;
  logic in_trig_sw = 1'b0, in_trig_analog = 1'b0, in_trig_digital = 1'b0;
  logic out_trig_sw = 1'b0, out_trig_analog = 1'b0, out_trig_digital = 1'b0;
  logic [11:0] role_cfg = 12'h555;
  logic [1:0] in_trig_sel = 2'h0, out_trig_sel = 2'h0;
  logic [5:0] internal_timing = 6'h3f, peer_en = 6'h00, peer_val = 6'h00;
  logic [5:0] board_sync_bus_in, board_sync_bus_out, board_sync_bus_oe, timing_used;
  int bad_count = 0, cmp_count = 0;
  always #5 clock = ~clock;
  card_timing_sync_router DUT (.*);
  peer_board PEER (.clock(clock), .peer_en(peer_en), .peer_val(peer_val),
    .dut_oe(board_sync_bus_oe), .dut_out(board_sync_bus_out), .line(board_sync_bus_in));
  task automatic step(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic t_reset;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    step(1);
    `CHK(board_sync_bus_oe, 6'h00)
    `CHK(timing_used, 6'h3f)
    step(2);
    `CHK(board_sync_bus_oe, 6'h3f)
    @(posedge clock) sys_rst <= 1'b1;
    step(1);
    `CHK(board_sync_bus_oe, 6'h00)
    @(posedge clock) sys_rst <= 1'b0;
    step(1);
    `CHK(board_sync_bus_oe, 6'h00)
    `CHK(timing_used, 6'h3f)
    $display("reset test done");
  endtask
  task automatic t_route(logic [5:0] v);
    // Roles: 0 and 2 master, 1 and 5 slave, 3 unused code, 4 disabled.
    @(posedge clock) role_cfg <= 12'h8d9;
    peer_en <= 6'h3a;
    internal_timing <= v;
    peer_val <= ~v;
    step(6);
    `CHK(board_sync_bus_oe, 6'h05)
    `CHK(board_sync_bus_out, v & 6'h05)
    `CHK(timing_used, (v & 6'h1d) | (~v & 6'h22))
    $display("route test done");
  endtask
  task automatic t_echo;
    logic [3:0] s, t;
    for (int k = 0; k < 8; k++) begin
      s = {4{~k[0]}} ^ (4'h1 << k[2:1]);
      t = {4{~k[0]}} ^ (4'h1 << ~k[2:1]);
      @(posedge clock) in_trig_sel <= k[2:1];
      out_trig_sel <= ~k[2:1];
      {in_trig_digital, in_trig_analog, in_trig_sw} <= s[2:0];
      {out_trig_digital, out_trig_analog, out_trig_sw} <= t[2:0];
      peer_val <= {1'b0, t[3], 2'h0, s[3], 1'b0};
      step(4);
      `CHK(input_trigger_echo, k[0])
      `CHK(output_trigger_echo, k[0])
    end
    $display("echo test done");
  endtask
  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    t_reset;
    t_route(6'h2a);
    t_route(6'h15);
    t_echo;
    summarize;
  end
  initial begin
    #5000;
    bad_count++;
    summarize;
  end
endmodule
